// ==== rtl/io_capture_path.sv ====
// Input capture path of one programmable I/O cell, with output pad multiplexer
// Overview of operation
// [RQ1] Each fabric output picks direct or registered
// [RQ2] Shared clock enable applied to input/output/both
// [RQ3] Clock enable fixed active high, never inverted
// [RQ4] Global set/reset forces configured init value
// [RQ5] Flop loads on rising edge; latch transparent
// [RQ6] Unconnected clock enable reads as high
// [RQ7] Unconnected clock or set/reset reads low
// [RQ8] Optional data delay, largest by default
// [RQ9] Single-tap variant: delay inserted or bypassed
// [RQ10] Two-tap variant: full, medium or none
// [RQ11] Early latch before storage, output clock
// [RQ12] Early latch then rising-edge flop
// [RQ13] Early latch then transparent-high latch
// [RQ14] Either capture clock optionally inverted
// [RQ15] Early latch in use: default medium delay
// [RQ16] Output clock selects data or enable
// [RQ17] Multiplexer may act as AND gate
// [RQ18] Early latch feeds second storage stage
//
// Design decisions made here: the address map and the APB register port.
`include "io_capture_map.svh"

module io_capture_path #(
	parameter bit TWO_TAP = 1'b1,
	parameter int FULL_TAPS = `CAP_FULL_TAPS,
	parameter int MED_TAPS = `CAP_MED_TAPS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CAP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pad side
	input wire logic pad_in,
	output logic pad_out,
	// Cell clocks, enable and global set/reset
	input wire logic in_clk,
	input wire logic out_clk,
	input wire logic shared_clk_en,
	input wire logic global_set_reset,
	// Fabric side
	input wire logic out_data,
	output logic fabric_in_a,
	output logic fabric_in_b
);
	import io_capture_pkg::*;

	// Register bus
	logic [`CAP_CTRL_W-1:0] ctrl_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	wire access = psel & penable;
	wire sel_ctrl = (paddr == `CAP_OFS_CTRL);
	wire sel_stat = (paddr == `CAP_OFS_STATUS);
	wire mapped = sel_ctrl | sel_stat;
	wire commit = access & pready_r;
	wire ctrl_we = commit & pwrite & sel_ctrl;
	logic [31:0] rd_mux;

	// Synchronisers for everything arriving from pins
	logic [1:0] pad_s_r;
	logic [1:0] iclk_s_r;
	logic [1:0] oclk_s_r;
	logic [1:0] ce_s_r;
	logic [1:0] gsr_s_r;
	wire pad_s = pad_s_r[1];

	// Configuration fields
	wire fab_a_reg = ctrl_r[`CAP_CTRL_A_REG];
	wire fab_b_reg = ctrl_r[`CAP_CTRL_B_REG];
	wire ce_to_in = ctrl_r[`CAP_CTRL_CE_IN];
	wire ce_to_out = ctrl_r[`CAP_CTRL_CE_OUT];
	wire latch_mode = ctrl_r[`CAP_CTRL_LATCH];
	wire init_value = ctrl_r[`CAP_CTRL_INIT_SET];
	wire early_capture_latch = ctrl_r[`CAP_CTRL_FCL];
	wire inv_iclk = ctrl_r[`CAP_CTRL_INV_ICLK];
	wire inv_oclk = ctrl_r[`CAP_CTRL_INV_OCLK];
	wire mux_and = ctrl_r[`CAP_CTRL_MUX_AND];
	wire ce_conn = ctrl_r[`CAP_CTRL_CE_CONN];
	wire iclk_conn = ctrl_r[`CAP_CTRL_ICLK_CONN];
	wire gsr_conn = ctrl_r[`CAP_CTRL_GSR_CONN];
	wire soft_gsr = ctrl_r[`CAP_CTRL_SOFT_GSR];
	delay_sel_t dly_cfg;
	delay_sel_t dly_eff;

	// Effective cell signals
	wire ce_eff = ce_conn ? ce_s_r[1] : 1'b1; // RQ6
	wire ce_plain = ce_eff; // RQ3
	wire iclk_raw = iclk_conn & iclk_s_r[1]; // RQ7
	wire gsr_eff = (gsr_conn & gsr_s_r[1]) | soft_gsr; // RQ7
	wire iclk_eff = iclk_raw ^ inv_iclk; // RQ14
	wire oclk_eff = oclk_s_r[1] ^ inv_oclk; // RQ14
	wire ce_in = ce_to_in ? ce_plain : 1'b1; // RQ2
	wire ce_out = ce_to_out ? ce_plain : 1'b1; // RQ2

	// Clock edge tracking on the effective clocks
	logic iclk_d_r;
	logic oclk_d_r;
	wire iclk_rise = iclk_eff & ~iclk_d_r;
	wire oclk_rise = oclk_eff & ~oclk_d_r;

	// Storage stages
	logic delayed;
	logic fcl_q_r;
	logic store_q_r;
	logic out_q_r;
	logic fab_a_r;
	logic fab_b_r;
	logic pad_out_r;
	wire store_d = early_capture_latch ? fcl_q_r : delayed; // RQ18
	// Second latch is transparent-high only behind the early latch
	wire latch_open = early_capture_latch ? iclk_eff : ~iclk_eff;
	wire flop_load = ~latch_mode & iclk_rise & ce_in; // RQ5 RQ12
	wire latch_load = latch_mode & latch_open & ce_in; // RQ5 RQ13
	wire store_load = flop_load | latch_load;
	wire fcl_open = early_capture_latch & ~oclk_eff; // RQ11
	wire out_load = oclk_rise & ce_out;
	wire mux_sel_out = mux_and ? (out_q_r & ce_plain) : // RQ17
		(oclk_eff ? out_q_r : ce_plain); // RQ16

	// Delay selection: auto resolves to full, or medium behind the early latch
	assign dly_cfg = delay_sel_t'(ctrl_r[`CAP_CTRL_DLY_HI:`CAP_CTRL_DLY_LO]);

	always_comb begin
		dly_eff = dly_cfg;
		unique case (dly_cfg)
			DLY_AUTO: begin
				dly_eff = early_capture_latch ? DLY_MEDIUM : DLY_FULL; // RQ8 RQ15
			end
			DLY_FULL: begin
				dly_eff = DLY_FULL;
			end
			DLY_MEDIUM: begin
				dly_eff = DLY_MEDIUM; // RQ10
			end
			DLY_NONE: begin
				dly_eff = DLY_NONE;
			end
		endcase
		// Single tap has only inserted or bypassed
		if (!TWO_TAP && dly_eff != DLY_NONE) begin
			dly_eff = DLY_FULL; // RQ9
		end
	end

	pad_delay_line #(
		.FULL_TAPS(FULL_TAPS),
		.MED_TAPS(MED_TAPS)
	) u_delay (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.din(pad_s),
		.sel(dly_eff),
		.dout(delayed)
	);

	// Pin synchronisers; first stage read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_s_r <= 2'h0;
			iclk_s_r <= 2'h0;
			oclk_s_r <= 2'h0;
			ce_s_r <= 2'h0;
			gsr_s_r <= 2'h0;
		end else if (clk_en) begin
			pad_s_r <= {pad_s_r[0], pad_in};
			iclk_s_r <= {iclk_s_r[0], in_clk};
			oclk_s_r <= {oclk_s_r[0], out_clk};
			ce_s_r <= {ce_s_r[0], shared_clk_en};
			gsr_s_r <= {gsr_s_r[0], global_set_reset};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iclk_d_r <= 1'b0;
			oclk_d_r <= 1'b0;
		end else if (clk_en) begin
			iclk_d_r <= iclk_eff;
			oclk_d_r <= oclk_eff;
		end
	end

	// Early capture latch, clocked by the output clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fcl_q_r <= 1'b0;
		else if (clk_en && fcl_open)
			fcl_q_r <= delayed; // RQ11
	end

	// Input storage element; set/reset overrides clock, enable and data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			store_q_r <= 1'b0; // RQ4
		else if (clk_en) begin
			if (gsr_eff)
				store_q_r <= init_value; // RQ4
			else if (store_load)
				store_q_r <= store_d; // RQ5
		end
	end

	// Output storage element shares the clock enable and set/reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			out_q_r <= 1'b0;
		else if (clk_en) begin
			if (gsr_eff)
				out_q_r <= init_value;
			else if (out_load)
				out_q_r <= out_data; // RQ2
		end
	end

	// Fabric outputs and pad output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fab_a_r <= 1'b0;
			fab_b_r <= 1'b0;
			pad_out_r <= 1'b0;
		end else if (clk_en) begin
			fab_a_r <= fab_a_reg ? store_q_r : pad_s; // RQ1
			fab_b_r <= fab_b_reg ? store_q_r : pad_s; // RQ1
			pad_out_r <= mux_sel_out; // RQ16
		end
	end

	// Read data selection
	always_comb begin
		rd_mux = 32'h0;
		if (sel_ctrl) begin
			rd_mux[`CAP_CTRL_W-1:0] = ctrl_r;
		end else if (sel_stat) begin
			rd_mux[`CAP_STAT_PAD] = pad_s;
			rd_mux[`CAP_STAT_DELAYED] = delayed;
			rd_mux[`CAP_STAT_FCL] = fcl_q_r;
			rd_mux[`CAP_STAT_STORE] = store_q_r;
			rd_mux[`CAP_STAT_FAB_A] = fab_a_r;
			rd_mux[`CAP_STAT_FAB_B] = fab_b_r;
			rd_mux[`CAP_STAT_OUT_Q] = out_q_r;
			rd_mux[`CAP_STAT_PAD_OUT] = pad_out_r;
			rd_mux[`CAP_STAT_DLY_HI:`CAP_STAT_DLY_LO] = dly_eff;
		end
	end

	// One wait state: pready rises on the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else if (clk_en) begin
			pready_r <= access & ~pready_r;
			if (access && !pready_r) begin
				pslverr_r <= ~mapped;
				prdata_r <= pwrite ? 32'h0 : rd_mux;
			end else begin
				pslverr_r <= 1'b0;
				prdata_r <= 32'h0;
			end
		end
	end

	// Status is read-only; writes there are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= `CAP_CTRL_RST;
		else if (clk_en && ctrl_we)
			ctrl_r <= pwdata[`CAP_CTRL_W-1:0];
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pad_out = pad_out_r;
	assign fabric_in_a = fab_a_r;
	assign fabric_in_b = fab_b_r;

endmodule : io_capture_path

// ==== rtl/io_capture_map.svh ====
// Register offsets, field positions, reset values and tap counts for the I/O capture path
`ifndef IO_CAPTURE_MAP_SVH
`define IO_CAPTURE_MAP_SVH

`define CAP_ADDR_W 12
`define CAP_OFS_CTRL 12'h000
`define CAP_OFS_STATUS 12'h004

// Control register fields
`define CAP_CTRL_A_REG 0
`define CAP_CTRL_B_REG 1
`define CAP_CTRL_CE_IN 2
`define CAP_CTRL_CE_OUT 3
`define CAP_CTRL_LATCH 4
`define CAP_CTRL_INIT_SET 5
`define CAP_CTRL_DLY_LO 6
`define CAP_CTRL_DLY_HI 7
`define CAP_CTRL_FCL 8
`define CAP_CTRL_INV_ICLK 9
`define CAP_CTRL_INV_OCLK 10
`define CAP_CTRL_MUX_AND 11
`define CAP_CTRL_CE_CONN 12
`define CAP_CTRL_ICLK_CONN 13
`define CAP_CTRL_GSR_CONN 14
`define CAP_CTRL_SOFT_GSR 15
`define CAP_CTRL_W 16
`define CAP_CTRL_RST 16'h700c

// Status register fields
`define CAP_STAT_PAD 0
`define CAP_STAT_DELAYED 1
`define CAP_STAT_FCL 2
`define CAP_STAT_STORE 3
`define CAP_STAT_FAB_A 4
`define CAP_STAT_FAB_B 5
`define CAP_STAT_OUT_Q 6
`define CAP_STAT_PAD_OUT 7
`define CAP_STAT_DLY_LO 8
`define CAP_STAT_DLY_HI 9

// Delay taps in pclk cycles
`define CAP_FULL_TAPS 4
`define CAP_MED_TAPS 2

`endif

// ==== rtl/io_capture_pkg.sv ====
// Types shared by the I/O capture path
package io_capture_pkg;

	typedef enum logic [1:0] {
		DLY_AUTO = 2'b00,
		DLY_FULL = 2'b01,
		DLY_MEDIUM = 2'b10,
		DLY_NONE = 2'b11
	} delay_sel_t;

endpackage : io_capture_pkg

// ==== rtl/pad_delay_line.sv ====
// Tapped delay line for the pad data, output taken from a register
`include "io_capture_map.svh"

module pad_delay_line #(
	parameter int FULL_TAPS = `CAP_FULL_TAPS,
	parameter int MED_TAPS = `CAP_MED_TAPS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Data
	input wire logic din,
	input wire io_capture_pkg::delay_sel_t sel,
	output logic dout
);
	import io_capture_pkg::*;

	logic [FULL_TAPS:0] tap;
	logic chosen;

	assign tap[0] = din;

	genvar i;
	generate
		for (i = 1; i <= FULL_TAPS; i++) begin : g_tap
			logic stage_r;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					stage_r <= 1'b0;
				else if (clk_en)
					stage_r <= tap[i-1];
			end
			assign tap[i] = stage_r;
		end
	endgenerate

	// Auto never reaches here; the caller resolves it first
	assign chosen = (sel == DLY_NONE) ? tap[0] :
		(sel == DLY_MEDIUM) ? tap[MED_TAPS] : tap[FULL_TAPS];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dout <= 1'b0;
		else if (clk_en)
			dout <= chosen;
	end

endmodule : pad_delay_line

// ==== test/io_capture_path_sva.sv ====
// Port checker for the I/O capture path
`include "io_capture_map.svh"

module io_capture_path_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CAP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Cell
	input wire logic pad_in,
	input wire logic global_set_reset,
	input wire logic fabric_in_a,
	input wire logic fabric_in_b
);
	logic [15:0] c_r;
	logic [2:0] k_r;
	// Shadow of the control word, so rules can be tied to the configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_r <= `CAP_CTRL_RST;
			k_r <= 3'h0;
		end else begin
			k_r <= k_r + 3'(k_r != 3'h7);
			if (psel && penable && pready && pwrite && paddr == `CAP_OFS_CTRL)
				c_r <= pwdata[15:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_wait_a: assert property (psel && penable && !pready && clk_en |=> pready)
		else $error("no answer");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	map_err_a: assert property (pready |->
		pslverr == !(paddr == `CAP_OFS_CTRL || paddr == `CAP_OFS_STATUS))
		else $error("wrong error response");
	ctrl_read_a: assert property (pready && !pwrite && paddr == `CAP_OFS_CTRL
		|-> prdata == {16'h0, c_r}) else $error("control readback wrong");
	// A frozen cycle stalls the synchroniser, so the three cycles behind must run
	direct_a_a: assert property (k_r == 3'h7 && !c_r[0] && !$past(c_r[0])
		&& $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3)
		|-> fabric_in_a == $past(pad_in, 3)) else $error("direct path a wrong");
	direct_b_a: assert property (k_r == 3'h7 && !c_r[1] && !$past(c_r[1])
		&& $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3)
		|-> fabric_in_b == $past(pad_in, 3)) else $error("direct path b wrong");
	gsr_force_a: assert property ((global_set_reset && c_r[14] && c_r[1])[*6]
		|-> fabric_in_b == c_r[5]) else $error("init value not forced");
endmodule : io_capture_path_sva

bind io_capture_path io_capture_path_sva chk_u (.pclk, .presetn, .clk_en, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in, .global_set_reset,
	.fabric_in_a, .fabric_in_b);

// ==== test/cell_env.sv ====
// Far-side model: pad data source and cell clocks
module cell_env (
	// Clock
	input wire logic pclk,
	// Bench control
	input wire logic run_clk,
	input wire logic run_pad,
	// Cell pins
	output logic pad_in,
	output logic in_clk,
	output logic out_clk,
	output logic out_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r = 4'h0;
	initial {pad_in, in_clk, out_clk, out_data} = 4'h0;
	// Cell clocks stand still low while stopped
	always @(posedge pclk) begin
		cnt_r <= cnt_r + 4'h1;
		in_clk <= run_clk & cnt_r[2];
		out_clk <= run_clk & cnt_r[3];
		if (run_pad) begin
			pad_in <= 1'($urandom);
			out_data <= 1'($urandom);
		end
	end
endmodule : cell_env

// ==== test/tb.sv ====
// Self-checking bench for the I/O capture path
`include "io_capture_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic shared_clk_en = 1'b0;
	logic global_set_reset = 1'b0;
	logic run_clk = 1'b0;
	logic run_pad = 1'b0;
	logic [31:0] prdata, rd, prdata1, rd1;
	logic pready, pslverr, err, pad_in, pad_out, in_clk, out_clk, out_data;
	logic fabric_in_a, fabric_in_b, v0;
	int n_mismatch = 0;
	int tests_run = 0;
	int ctrl_m, e_ce, n;
	int dq[$];
	io_capture_path dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .in_clk, .out_clk,
		.shared_clk_en, .global_set_reset, .out_data, .fabric_in_a, .fabric_in_b);
	// Single-tap variant on the same bus, only its delay field is compared
	io_capture_path #(.TWO_TAP(1'b0)) one_tap_u (.pclk, .presetn, .clk_en, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata(prdata1), .pready(), .pslverr(), .pad_in,
		.pad_out(), .in_clk, .out_clk, .shared_clk_en, .global_set_reset, .out_data,
		.fabric_in_a(), .fabric_in_b());
	cell_env env_u (.pclk, .run_clk, .run_pad, .pad_in, .in_clk, .out_clk, .out_data);
	always #50 pclk = ~pclk;
	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		rd1 = prdata1;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wctl(input logic [31:0] v);
		apb(1'b1, `CAP_OFS_CTRL, v);
		ctrl_m = v & 32'hffff;
	endtask : wctl
	task automatic hold(input int c, input logic e);
		repeat (c) begin
			@(posedge pclk);
			check("hold", 32'(fabric_in_a), 32'(e));
		end
	endtask : hold
	task automatic follow(input int lat);
		int q[$];
		repeat (40) begin
			@(posedge pclk);
			q.push_back(int'(pad_in));
			if (q.size() > lat)
				check("follow", 32'(fabric_in_a), 32'(q.pop_front()));
		end
	endtask : follow
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	initial begin
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		conclude();
	end
	initial begin
		void'($urandom(32'h4212));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `CAP_OFS_CTRL, 32'h0);
		check("ctrl rst", rd, 32'(`CAP_CTRL_RST));
		apb(1'b1, 12'h008, 32'hffff);
		check("unmapped", 32'(err), 32'h1);
		apb(1'b1, `CAP_OFS_STATUS, 32'hffffffff);
		wctl($urandom);
		apb(1'b0, `CAP_OFS_CTRL, 32'h0);
		check("ctrl rd", rd, ctrl_m);
		for (int i = 0; i < 8; i++) begin
			wctl(32'h700c | (i[1:0] << 6) | (i[2] << 8));
			apb(1'b0, `CAP_OFS_STATUS, 32'h0);
			check("delay", 32'(rd[9:8]), i[1:0] != 0 ? i[1:0] : (i[2] ? 2 : 1));
			check("delay one tap", 32'(rd1[9:8]), i[1:0] == 3 ? 3 : 1);
		end
		// Soft set/reset pins the flops, so pad_out is a pure function of config and shared_clk_en
		for (int i = 0; i < 32; i++) begin
			shared_clk_en <= i[3];
			wctl(32'ha00f | (i[0] << 5) | (i[1] << 10) | (i[2] << 11) | (i[4] << 12));
			repeat (6) @(posedge pclk);
			e_ce = i[4] ? i[3] : 1;
			check("pad", 32'(pad_out), i[2] ? i[0] & e_ce : (i[1] ? i[0] : e_ce));
			check("fab b", 32'(fabric_in_b), 32'(i[0]));
		end
		shared_clk_en <= 1'b1;
		run_pad <= 1'b1;
		wctl(32'h7007);
		v0 = fabric_in_a;
		hold(20, v0);
		shared_clk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		run_clk <= 1'b1;
		hold(40, v0);
		wctl(32'h7001);
		n = 0;
		repeat (80) begin
			@(posedge pclk);
			n += 32'(fabric_in_a !== v0);
			dq.push_back(int'(pad_in));
			if (dq.size() > 3)
				check("direct b", 32'(fabric_in_b), 32'(dq.pop_front()));
		end
		check("ce off input", 32'(n > 0), 32'h1);
		// Block enable low freezes every stage while pad and clocks keep moving
		clk_en <= 1'b0;
		@(posedge pclk);
		v0 = fabric_in_a;
		e_ce = fabric_in_b;
		repeat (30) begin
			@(posedge pclk);
			check("freeze a", 32'(fabric_in_a), 32'(v0));
			check("freeze b", 32'(fabric_in_b), 32'(e_ce));
		end
		clk_en <= 1'b1;
		run_clk <= 1'b0;
		// Open latch: full delay 7, storage 1, fabric flop 1
		wctl(32'h7011);
		follow(9);
		// Early latch into inverted-clock latch, auto delay drops to medium
		wctl(32'h7311);
		follow(8);
		wctl(32'hb002);
		wctl(32'h3022);
		global_set_reset <= 1'b1;
		repeat (10) @(posedge pclk);
		check("gsr unconnected", 32'(fabric_in_b), 32'h0);
		wctl(32'h7022);
		repeat (8) @(posedge pclk);
		check("gsr set", 32'(fabric_in_b), 32'h1);
		global_set_reset <= 1'b0;
		wctl(32'h700c);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		check("rst pad", 32'(pad_out), 32'h0);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `CAP_OFS_CTRL, 32'h0);
		check("ctrl rst again", rd, 32'(`CAP_CTRL_RST));
		conclude();
	end
endmodule : tb
